// *** verilog/charge_ctrl.sv ***
// charge safety timer, power path status and battery switch ship mode control
//
// The register offsets and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
module charge_ctrl #(
    parameter int TICK_CYCLES = charge_ctrl_pkg::TICK_CYCLES_DEF
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire charge_ctrl_pkg::sense_t sense_in,
    input wire logic charge_enable_pin_n,
    input wire logic button_pin_n,
    output logic battery_switch_on,
    output logic supplement_active,
    output logic charge_reduce,
    output logic [2:0] min_system_voltage_sel,
    output logic [1:0] charge_fault_code,
    output logic fault_int_pulse,
    output logic topoff_done
);
    import charge_ctrl_pkg::*;

    localparam int PRE_W = $clog2(TICK_CYCLES + 1);

    // two-stage synchronisers for the sense inputs and both pins; AHB inputs are used directly
    logic [SENSE_W+1:0] sync1_reg;
    logic [SENSE_W+1:0] sync2_reg;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_reg <= {PIN_IDLE, {SENSE_W{1'b0}}};
            sync2_reg <= {PIN_IDLE, {SENSE_W{1'b0}}};
        end else begin
            sync1_reg <= {charge_enable_pin_n, button_pin_n, sense_in};
            sync2_reg <= sync1_reg;
        end
    end
    sense_t s;
    logic chg_pin_n_s;
    logic btn_n_s;
    assign s = sense_t'(sync2_reg[SENSE_W-1:0]);
    assign btn_n_s = sync2_reg[SENSE_W];
    assign chg_pin_n_s = sync2_reg[SENSE_W+1];

    // ahb-lite slave, zero wait states, always OKAY
    ctrl_t ctrl_reg;
    ship_t ship_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic addr_ok;
    logic regrst;
    logic ship_clear;
    logic [STATUS_W-1:0] status;
    logic [TCNT_W-1:0] safety_cnt_reg;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addr_ok = hsel && hready && htrans[1];
    assign regrst = wr_pend_reg && wr_addr_reg == SHIP_OFFSET && hwdata[REGRST_BIT];

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= CTRL_OFFSET;
        end else begin
            wr_pend_reg <= addr_ok && hwrite;
            wr_addr_reg <= haddr[7:0];
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            hrdata <= WORD_ZERO;
        end else if (addr_ok && !hwrite) begin
            unique case (haddr[7:0])
                CTRL_OFFSET: hrdata <= {{(32-CTRL_W){1'b0}}, ctrl_reg};
                SHIP_OFFSET: hrdata <= {{(32-SHIP_W){1'b0}}, ship_reg};
                STATUS_OFFSET: hrdata <= {{(32-STATUS_W){1'b0}}, status};
                TIMER_OFFSET: hrdata <= {{(32-TCNT_W){1'b0}}, safety_cnt_reg};
                default: hrdata <= WORD_ZERO;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg <= CTRL_RESET;
            ship_reg <= SHIP_RESET;
        end else if (regrst) begin
            ctrl_reg <= CTRL_RESET;
            ship_reg <= SHIP_RESET;
        end else begin
            if (wr_pend_reg && wr_addr_reg == CTRL_OFFSET) begin
                ctrl_reg <= ctrl_t'(hwdata[CTRL_W-1:0]);
            end
            if (wr_pend_reg && wr_addr_reg == SHIP_OFFSET) begin
                ship_reg <= ship_t'(hwdata[SHIP_W-1:0]);
            end else if (ship_clear) begin
                ship_reg.battery_switch_disable <= 1'b0;
            end
        end
    end
    assign min_system_voltage_sel = ctrl_reg.min_system_voltage_sel;

    // prescaled tick and half-rate phase
    logic [PRE_W-1:0] pre_cnt_reg;
    logic tick;
    logic half_phase_reg;
    assign tick = pre_cnt_reg == PRE_W'(TICK_CYCLES - 1);
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pre_cnt_reg <= '0;
        end else begin
            pre_cnt_reg <= tick ? '0 : pre_cnt_reg + 1'b1;
        end
    end
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            half_phase_reg <= 1'b0;
        end else if (tick) begin
            half_phase_reg <= !half_phase_reg;
        end
    end

    // safety timer
    logic chg_on;
    logic chg_on_d_reg;
    logic restart;
    logic half_active;
    logic expired_reg;
    logic advance;
    logic expire;
    logic [TCNT_W-1:0] limit;
    assign chg_on = ctrl_reg.charge_enable_bit && !chg_pin_n_s;
    assign restart = chg_on && !chg_on_d_reg;
    assign half_active = ctrl_reg.half_rate_timer_enable &&
        (s.vin_limit || s.iin_limit || s.cool_reduce || s.therm_reg);
    assign advance = tick && chg_on && !expired_reg && !s.fault
        && (!half_active || half_phase_reg);
    assign limit = s.bat_low ? PRECHG_TICKS
        : fast_limit(ctrl_reg.fast_charge_time_select);
    assign expire = advance && ctrl_reg.timer_enable && safety_cnt_reg + 1'b1 >= limit;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            chg_on_d_reg <= 1'b0;
        end else begin
            chg_on_d_reg <= chg_on;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            safety_cnt_reg <= '0;
        end else if (!ctrl_reg.timer_enable || restart) begin
            safety_cnt_reg <= '0;
        end else if (advance && !expire) begin
            safety_cnt_reg <= safety_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            expired_reg <= 1'b0;
            charge_fault_code <= FAULT_NONE;
            fault_int_pulse <= 1'b0;
        end else begin
            fault_int_pulse <= expire;
            if (expire) begin
                expired_reg <= 1'b1;
                charge_fault_code <= FAULT_TIMER;
            end else if (restart || !ctrl_reg.timer_enable) begin
                expired_reg <= 1'b0;
                charge_fault_code <= FAULT_NONE;
            end
        end
    end

    // top-off timer shares the safety timer's suspend and half-rate gating
    logic term_d_reg;
    logic topoff_active_reg;
    logic [TCNT_W-1:0] topoff_cnt_reg;
    logic [TCNT_W-1:0] topoff_lim_reg;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            term_d_reg <= 1'b0;
            topoff_active_reg <= 1'b0;
            topoff_cnt_reg <= '0;
            topoff_lim_reg <= '0;
            topoff_done <= 1'b0;
        end else begin
            term_d_reg <= s.term_detect;
            topoff_done <= 1'b0;
            if (restart || regrst) begin
                topoff_active_reg <= 1'b0;
                topoff_cnt_reg <= '0;
            end else if (s.term_detect && !term_d_reg) begin
                topoff_active_reg <= ctrl_reg.topoff_sel != 2'h0;
                topoff_lim_reg <= TCNT_W'(ctrl_reg.topoff_sel * TOPOFF_STEP_TICKS);
                topoff_cnt_reg <= '0;
            end else if (topoff_active_reg && advance) begin
                topoff_cnt_reg <= topoff_cnt_reg + 1'b1;
                if (topoff_cnt_reg + 1'b1 >= topoff_lim_reg) begin
                    topoff_active_reg <= 1'b0;
                    topoff_done <= 1'b1;
                end
            end
        end
    end

    // power path status and supplement mode
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            supplement_active <= 1'b0;
            charge_reduce <= 1'b0;
        end else begin
            charge_reduce <= s.vin_limit || s.iin_limit;
            if (s.bat_depleted) begin
                supplement_active <= 1'b0;
            end else if (s.bat_above_min ? s.sys_dip_10mv : s.sys_dip_20mv) begin
                supplement_active <= 1'b1;
            end
        end
    end
    assign status = {topoff_active_reg, expired_reg, supplement_active, battery_switch_on,
        s.iin_limit, s.vin_limit, 1'b0, s.sys_at_min};

    // push-button counters and battery switch state
    logic [BCNT_W-1:0] btn_cnt_reg;
    logic btn_armed_reg;
    logic btn_exit;
    logic btn_reset;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            btn_cnt_reg <= '0;
            btn_armed_reg <= 1'b0;
        end else if (btn_n_s) begin
            btn_cnt_reg <= '0;
            btn_armed_reg <= 1'b1;
        end else if (tick && btn_cnt_reg != BTN_RST_TICKS) begin
            btn_cnt_reg <= btn_cnt_reg + 1'b1;
        end
    end
    assign btn_exit = btn_armed_reg && btn_cnt_reg >= SHIP_EXIT_TICKS;
    assign btn_reset = btn_cnt_reg == BTN_RST_TICKS && !s.adapter
        && ship_reg.system_reset_function_enable;

    sw_state_t sw_state_reg;
    logic [BCNT_W-1:0] sw_cnt_reg;
    assign ship_clear = sw_state_reg == SW_SHIP && (s.adapter || btn_exit);
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sw_state_reg <= SW_ON;
            sw_cnt_reg <= '0;
        end else begin
            unique case (sw_state_reg)
                SW_ON: begin
                    sw_cnt_reg <= '0;
                    if (ship_reg.battery_switch_disable) begin
                        sw_state_reg <= ship_reg.ship_entry_delay_sel ? SW_DELAY : SW_SHIP;
                    end else if (btn_reset) begin
                        sw_state_reg <= SW_RESET;
                    end
                end
                SW_DELAY: begin
                    if (!ship_reg.battery_switch_disable) begin
                        sw_state_reg <= SW_ON;
                    end else if (tick) begin
                        sw_cnt_reg <= sw_cnt_reg + 1'b1;
                        if (sw_cnt_reg + 1'b1 >= SHIP_DLY_TICKS) begin
                            sw_state_reg <= SW_SHIP;
                        end
                    end
                end
                SW_SHIP: begin
                    if (!ship_reg.battery_switch_disable || ship_clear) begin
                        sw_state_reg <= SW_ON;
                    end
                end
                SW_RESET: begin
                    if (tick) begin
                        sw_cnt_reg <= sw_cnt_reg + 1'b1;
                        if (sw_cnt_reg + 1'b1 >= SW_OFF_TICKS) begin
                            sw_state_reg <= SW_ON;
                            sw_cnt_reg <= '0;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            battery_switch_on <= 1'b0;
        end else begin
            battery_switch_on <= (sw_state_reg == SW_ON || sw_state_reg == SW_DELAY)
                && !(s.bat_depleted && !s.adapter);
        end
    end

    chk_fault_code_set: assert property (@(posedge sys_clk) disable iff (!resetn)
        expire |=> charge_fault_code == FAULT_TIMER && fault_int_pulse)
        else $error("timer expiry did not raise fault code");
    chk_int_one_cycle: assert property (@(posedge sys_clk) disable iff (!resetn)
        fault_int_pulse |=> !fault_int_pulse)
        else $error("interrupt pulse longer than one cycle");
    chk_timer_off_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
        !ctrl_reg.timer_enable |=> safety_cnt_reg == '0 && !fault_int_pulse)
        else $error("disabled timer still counting");
    chk_fault_freeze: assert property (@(posedge sys_clk) disable iff (!resetn)
        s.fault && !restart && ctrl_reg.timer_enable |=> $stable(safety_cnt_reg))
        else $error("timer moved during fault");
    chk_restart_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
        restart |=> safety_cnt_reg == '0)
        else $error("restart did not clear timer");
    chk_half_rate: assert property (@(posedge sys_clk) disable iff (!resetn)
        advance && half_active |-> half_phase_reg)
        else $error("half rate timer advanced on wrong tick");
    chk_full_rate: assert property (@(posedge sys_clk) disable iff (!resetn)
        tick && chg_on && !expired_reg && !s.fault && !ctrl_reg.half_rate_timer_enable
        |-> advance)
        else $error("full rate timer skipped a tick");
    chk_reg_reset: assert property (@(posedge sys_clk) disable iff (!resetn)
        regrst |=> ctrl_reg == CTRL_RESET && !ship_reg.battery_switch_disable)
        else $error("register reset left non-default values");
    chk_supp_exit: assert property (@(posedge sys_clk) disable iff (!resetn)
        s.bat_depleted |=> !supplement_active)
        else $error("supplement mode kept on depleted battery");
    chk_ship_now: assert property (@(posedge sys_clk) disable iff (!resetn)
        sw_state_reg == SW_ON && ship_reg.battery_switch_disable
        && !ship_reg.ship_entry_delay_sel |=> sw_state_reg == SW_SHIP ##1 !battery_switch_on)
        else $error("immediate ship mode not entered");
    chk_reset_off: assert property (@(posedge sys_clk) disable iff (!resetn)
        sw_state_reg == SW_RESET |=> !battery_switch_on)
        else $error("switch closed during full system reset");
    chk_reset_fn_off: assert property (@(posedge sys_clk) disable iff (!resetn)
        sw_state_reg != SW_RESET && !ship_reg.system_reset_function_enable
        |=> sw_state_reg != SW_RESET)
        else $error("button reset ran while disabled");
endmodule

// *** verilog/charge_ctrl_pkg.sv ***
// constants, types and register map of the charge timer and ship mode controller
// Overview of operation
// - Below the low-battery threshold the safety timer limit is fixed at two hours.
// - Host picks the fast-charge timer length; the device uses that pick.
// - On safety timer expiry set charge fault code 11 and pulse the interrupt.
// - Clearing the timer enable bit stops the safety timer entirely.
// - Input voltage or current limit, thermal regulation or cool reduction makes the safety timer run at half rate.
// - Writing 0 to the half-rate enable keeps the timer at full rate.
// - A present fault freezes the timer; counting resumes from the held value.
// - Stopping and restarting a charge cycle resets the safety timer to zero.
// - Minimum system voltage comes from a three-bit field, reset pick 3.5 V.
// - Flag system-minimum regulation while the rail is held at minimum voltage.
// - Input current or voltage limit hit reduces charge current until cleared.
// - Input voltage and current limit status bits follow the active limits.
// - Rail 10 mV or 20 mV below battery closes the switch: supplement mode.
// - Battery below depletion threshold with no input opens the switch; supplement mode always ends.
// - Switch disable bit opens the switch at once or after the ship delay.
// - Ship mode ends on adapter, disable clear, register reset or 1.15 s button.
// - Register reset bit restores all defaults; switch disable returns to 0.
// - Button low 12 s, no input, switch enabled: open switch 10 s, reclose.
// - Reset-enable bit at 0 suppresses the push-button full system reset.
// - Top-off timer suspends and slows exactly like the safety timer.
package charge_ctrl_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_TIME_MS = 10;
    localparam int TICK_CYCLES_DEF = TICK_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TICKS_PER_HOUR = 3600 * 1000 / TICK_TIME_MS;
    localparam int PRECHG_HOURS = 2;
    localparam int SHIP_EXIT_MS = 1150;
    localparam int BTN_RST_MS = 12000;
    localparam int SW_OFF_RST_MS = 10000;
    localparam int SHIP_DLY_MS = 10000;
    localparam int TOPOFF_STEP_MIN = 15;
    localparam int TCNT_W = 24;
    localparam int BCNT_W = 11;
    localparam logic [TCNT_W-1:0] PRECHG_TICKS = TCNT_W'(PRECHG_HOURS * TICKS_PER_HOUR);
    localparam logic [BCNT_W-1:0] SHIP_EXIT_TICKS =
        BCNT_W'((SHIP_EXIT_MS + TICK_TIME_MS - 1) / TICK_TIME_MS);
    localparam logic [BCNT_W-1:0] BTN_RST_TICKS =
        BCNT_W'((BTN_RST_MS + TICK_TIME_MS - 1) / TICK_TIME_MS);
    localparam logic [BCNT_W-1:0] SW_OFF_TICKS = BCNT_W'(SW_OFF_RST_MS / TICK_TIME_MS);
    localparam logic [BCNT_W-1:0] SHIP_DLY_TICKS = BCNT_W'(SHIP_DLY_MS / TICK_TIME_MS);
    localparam logic [TCNT_W-1:0] TOPOFF_STEP_TICKS =
        TCNT_W'(TOPOFF_STEP_MIN * 60 * 1000 / TICK_TIME_MS);

    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] SHIP_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    localparam logic [7:0] TIMER_OFFSET = 8'h0C;
    localparam int CTRL_W = 10;
    localparam int SHIP_W = 3;
    localparam int REGRST_BIT = 7;
    localparam int STATUS_W = 8;
    localparam logic [1:0] FAULT_NONE = 2'h0;
    localparam logic [1:0] FAULT_TIMER = 2'h3;
    localparam logic [1:0] PIN_IDLE = 2'h3;
    localparam logic [31:0] WORD_ZERO = 32'h0;

    typedef struct packed {
        logic [1:0] topoff_sel;
        logic [2:0] min_system_voltage_sel;
        logic [1:0] fast_charge_time_select;
        logic half_rate_timer_enable;
        logic timer_enable;
        logic charge_enable_bit;
    } ctrl_t;
    localparam ctrl_t CTRL_RESET = 10'h0AF;

    typedef struct packed {
        logic system_reset_function_enable;
        logic ship_entry_delay_sel;
        logic battery_switch_disable;
    } ship_t;
    localparam ship_t SHIP_RESET = 3'h4;

    typedef struct packed {
        logic bat_low;
        logic vin_limit;
        logic iin_limit;
        logic cool_reduce;
        logic therm_reg;
        logic fault;
        logic sys_at_min;
        logic sys_dip_10mv;
        logic sys_dip_20mv;
        logic bat_above_min;
        logic bat_depleted;
        logic adapter;
        logic term_detect;
    } sense_t;
    localparam int SENSE_W = $bits(sense_t);

    typedef enum logic [1:0] {SW_ON, SW_DELAY, SW_SHIP, SW_RESET} sw_state_t;

    function automatic logic [TCNT_W-1:0] fast_limit(input logic [1:0] sel);
        case (sel)
            2'h0: fast_limit = TCNT_W'(5 * TICKS_PER_HOUR);
            2'h1: fast_limit = TCNT_W'(8 * TICKS_PER_HOUR);
            2'h2: fast_limit = TCNT_W'(12 * TICKS_PER_HOUR);
            default: fast_limit = TCNT_W'(20 * TICKS_PER_HOUR);
        endcase
    endfunction
endpackage

// *** dv/button_model.sv ***
// push-button model on the active-low button pin
`timescale 1ns/1ps
module button_model (
    input wire logic press,
    output logic button_pin_n
);
    // pulled up while released, pulled low only while pressed
    assign button_pin_n = press ? 1'b0 : 1'b1;
endmodule

// *** dv/testbench.sv ***
// self-checking testbench of the charge timer and ship mode controller
`timescale 1ns/1ps
module testbench;
    import charge_ctrl_pkg::*;
    localparam int TK = 4;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, fault_int_pulse, topoff_done;
    logic [31:0] hrdata;
    sense_t sense = '0;
    logic charge_enable_pin_n = 1'b0;
    logic press = 1'b0;
    logic button_pin_n, battery_switch_on, supplement_active, charge_reduce;
    logic [2:0] min_system_voltage_sel;
    logic [1:0] charge_fault_code;
    int n_mismatch = 0;
    int n_compared = 0;
    logic [31:0] rd, t0;

    button_model i_button (.press(press), .button_pin_n(button_pin_n));
    charge_ctrl #(.TICK_CYCLES(TK)) i_dut (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .sense_in(sense), .charge_enable_pin_n(charge_enable_pin_n),
        .button_pin_n(button_pin_n), .battery_switch_on(battery_switch_on),
        .supplement_active(supplement_active), .charge_reduce(charge_reduce),
        .min_system_voltage_sel(min_system_voltage_sel),
        .charge_fault_code(charge_fault_code), .fault_int_pulse(fault_int_pulse),
        .topoff_done(topoff_done));

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // waits for hready sampled high at a rising edge; a run-out ends the run
    task automatic wait_ready();
        int k;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1) begin
            n_mismatch++;
            $display("ERROR bus wait expected ready seen timeout");
            results();
        end
    endtask

    // one single AHB transfer, holding each phase until hready is sampled high
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    // timer advance over 40 cycles, ten ticks at full rate
    task automatic span(input string name, input int lo, input int hi);
        logic [31:0] d;
        bus(1'b0, TIMER_OFFSET, WORD_ZERO);
        t0 = rd;
        repeat (40) @(posedge sys_clk);
        bus(1'b0, TIMER_OFFSET, WORD_ZERO);
        d = rd - t0;
        check(name, 32'(d >= lo && d <= hi), 32'h1);
    endtask

    task automatic test_reset_values();
        bus(1'b0, CTRL_OFFSET, WORD_ZERO);
        check("ctrl reset", rd, 32'h0AF);
        check("bus okay", 32'(hresp), 32'h0);
        bus(1'b0, SHIP_OFFSET, WORD_ZERO);
        check("ship reset", rd, 32'h4);
        check("min sys sel", 32'(min_system_voltage_sel), 32'h5);
        $display("test reset values done");
    endtask

    task automatic test_timer();
        span("full rate", 9, 12);
        sense.fault <= 1'b1;
        repeat (5) @(posedge sys_clk);
        span("frozen", 0, 0);
        sense.fault <= 1'b0;
        span("resumed", 9, 12);
        sense.therm_reg <= 1'b1;
        span("half rate", 4, 7);
        bus(1'b1, CTRL_OFFSET, 32'h0AB);
        span("half disabled", 9, 12);
        bus(1'b1, CTRL_OFFSET, 32'h0AD);
        span("timer off", 0, 0);
        sense.therm_reg <= 1'b0;
        bus(1'b1, CTRL_OFFSET, 32'h0AF);
        repeat (40) @(posedge sys_clk);
        bus(1'b0, TIMER_OFFSET, WORD_ZERO);
        check("count before", 32'(rd >= 32'h5), 32'h1);
        bus(1'b1, CTRL_OFFSET, 32'h0AE);
        bus(1'b1, CTRL_OFFSET, 32'h0AF);
        bus(1'b0, TIMER_OFFSET, WORD_ZERO);
        check("restart low", 32'(rd <= 32'h3), 32'h1);
        check("no fault", 32'(charge_fault_code), 32'h0);
        check("no int", 32'(fault_int_pulse), 32'h0);
        check("no topoff", 32'(topoff_done), 32'h0);
        $display("test timer done");
    endtask

    task automatic test_status();
        sense.sys_at_min <= 1'b1;
        sense.vin_limit <= 1'b1;
        sense.iin_limit <= 1'b1;
        repeat (5) @(posedge sys_clk);
        bus(1'b0, STATUS_OFFSET, WORD_ZERO);
        check("status bits", rd & 32'h0D, 32'h0D);
        check("reduce on", 32'(charge_reduce), 32'h1);
        sense.sys_at_min <= 1'b0;
        sense.vin_limit <= 1'b0;
        sense.iin_limit <= 1'b0;
        repeat (5) @(posedge sys_clk);
        bus(1'b0, STATUS_OFFSET, WORD_ZERO);
        check("status clear", rd & 32'h0D, 32'h0);
        check("reduce off", 32'(charge_reduce), 32'h0);
        $display("test status done");
    endtask

    task automatic test_supplement();
        sense.sys_dip_10mv <= 1'b1;
        repeat (6) @(posedge sys_clk);
        check("suppl low 10", 32'(supplement_active), 32'h0);
        sense.sys_dip_20mv <= 1'b1;
        repeat (6) @(posedge sys_clk);
        check("suppl low 20", 32'(supplement_active), 32'h1);
        sense.bat_depleted <= 1'b1;
        repeat (6) @(posedge sys_clk);
        check("suppl off low", 32'(supplement_active), 32'h0);
        sense <= '0;
        repeat (6) @(posedge sys_clk);
        sense.bat_above_min <= 1'b1;
        sense.sys_dip_10mv <= 1'b1;
        repeat (6) @(posedge sys_clk);
        check("suppl on", 32'(supplement_active), 32'h1);
        sense.bat_depleted <= 1'b1;
        repeat (6) @(posedge sys_clk);
        check("suppl off", 32'(supplement_active), 32'h0);
        check("switch off", 32'(battery_switch_on), 32'h0);
        sense <= '0;
        repeat (6) @(posedge sys_clk);
        $display("test supplement done");
    endtask

    task automatic test_ship();
        bus(1'b1, SHIP_OFFSET, 32'h5);
        repeat (10) @(posedge sys_clk);
        check("ship now", 32'(battery_switch_on), 32'h0);
        bus(1'b1, SHIP_OFFSET, 32'h4);
        repeat (10) @(posedge sys_clk);
        check("exit clear", 32'(battery_switch_on), 32'h1);
        bus(1'b1, SHIP_OFFSET, 32'h7);
        repeat (100) @(posedge sys_clk);
        check("delay on", 32'(battery_switch_on), 32'h1);
        repeat (1000 * TK) @(posedge sys_clk);
        check("delay off", 32'(battery_switch_on), 32'h0);
        bus(1'b1, SHIP_OFFSET, 32'h80);
        repeat (10) @(posedge sys_clk);
        check("exit regrst", 32'(battery_switch_on), 32'h1);
        bus(1'b0, SHIP_OFFSET, WORD_ZERO);
        check("regrst ship", rd, 32'h4);
        bus(1'b1, SHIP_OFFSET, 32'h5);
        press <= 1'b1;
        repeat (60 * TK) @(posedge sys_clk);
        press <= 1'b0;
        repeat (20) @(posedge sys_clk);
        check("short press", 32'(battery_switch_on), 32'h0);
        press <= 1'b1;
        repeat (125 * TK) @(posedge sys_clk);
        check("button exit", 32'(battery_switch_on), 32'h1);
        press <= 1'b0;
        repeat (10) @(posedge sys_clk);
        bus(1'b0, SHIP_OFFSET, WORD_ZERO);
        check("disable clr", rd, 32'h4);
        bus(1'b1, SHIP_OFFSET, 32'h5);
        sense.adapter <= 1'b1;
        repeat (10) @(posedge sys_clk);
        check("exit adapter", 32'(battery_switch_on), 32'h1);
        sense.adapter <= 1'b0;
        bus(1'b0, SHIP_OFFSET, WORD_ZERO);
        check("adapter clr", rd, 32'h4);
        $display("test ship done");
    endtask

    task automatic test_button_reset();
        press <= 1'b1;
        repeat (1225 * TK) @(posedge sys_clk);
        check("reset off", 32'(battery_switch_on), 32'h0);
        press <= 1'b0;
        repeat (1050 * TK) @(posedge sys_clk);
        check("reset back", 32'(battery_switch_on), 32'h1);
        bus(1'b1, SHIP_OFFSET, 32'h0);
        press <= 1'b1;
        repeat (1250 * TK) @(posedge sys_clk);
        check("reset masked", 32'(battery_switch_on), 32'h1);
        press <= 1'b0;
        $display("test button reset done");
    endtask

    initial begin
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        test_reset_values();
        test_timer();
        test_status();
        test_supplement();
        test_ship();
        test_button_reset();
        results();
    end
endmodule
